// ===== dv/can_error_status_bit_timing_tb.sv
module can_error_status_bit_timing_tb import cesbt_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    cesbt_req_t req = '0;
    cesbt_evt_t evt = cesbt_evt_t'(14'h20);
    logic hold_dom = 1'b0;
    logic [15:0] rdata;
    logic can_rx;
    logic can_tx;
    logic sample_pulse;
    logic sample_bit;
    logic status_irq;
    logic bus_off;
    logic init_active;
    int err_total = 0;
    int checks_done = 0;
    int ebit[7] = '{13, 12, 11, 9, 10, 8, 7};
    logic [2:0] ecode[7] = '{CODE_STUFF, CODE_FORM, CODE_ACK, CODE_REC_DRV,
        CODE_DOM_DRV, CODE_CRC, CODE_NONE};

    cesbt_core #(.RECOVERY_SEQS(2), .IDLE_RUN_BITS(3)) dut (
        .clk(clk), .srst(srst), .req(req), .rdata(rdata), .evt(evt),
        .can_rx(can_rx), .can_tx(can_tx), .sample_pulse(sample_pulse),
        .sample_bit(sample_bit), .status_irq(status_irq), .bus_off(bus_off),
        .init_active(init_active));

    cesbt_node node (.clk(clk), .can_tx(can_tx), .hold_dom(hold_dom), .can_rx(can_rx));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1 v = rdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] v;
        rd(a, v);
        chk(v, e);
    endtask

    task automatic pulse(input int b, input int n);
        repeat (n) begin
            @(posedge clk);
            evt <= cesbt_evt_t'(14'(14'h20 | (14'h1 << b)));
            @(posedge clk);
            evt <= cesbt_evt_t'(14'h20);
        end
    endtask

    task automatic measure(input int e);
        int n;
        n = 0;
        while (sample_pulse !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        n = 0;
        do begin
            tick(1);
            n++;
        end while (sample_pulse !== 1'b1 && n < 3000);
        chk(16'(n), 16'(e));
    endtask

    task automatic t_reset();
        rdc(OFS_CTRL, 16'h0001);
        rdc(OFS_BTR, {1'b0, BTR_RST});
        rdc(OFS_FAULT, 16'h0000);
        rdc(OFS_STAT, 16'h0000);
        rdc(8'h1c, 16'h0000);
        rdc(OFS_CTRL, 16'h0001);
        tick(1);
        chk(rdata, 16'h0000);
        chk(can_tx, 1'b1);
        chk(init_active, 1'b1);
        $display("reset values done");
    endtask

    task automatic t_protect();
        wr(OFS_BTR, 16'hffff);
        rdc(OFS_BTR, 16'h2301);
        wr(OFS_CTRL, 16'h0041);
        wr(OFS_BTR, 16'hffff);
        rdc(OFS_BTR, 16'h7fff);
        wr(OFS_BTR, 16'h2301);
        $display("timing protect done");
    endtask

    task automatic t_codes();
        logic [15:0] v;
        wr(OFS_CTRL, 16'h0006);
        for (int i = 0; i < 7; i++) begin
            pulse(ebit[i], 1);
            rd(OFS_STAT, v);
            chk(16'(v[2:0]), 16'(ecode[i]));
        end
        $display("fault codes done");
    endtask

    task automatic t_status();
        logic [15:0] v;
        rd(OFS_STAT, v);
        wr(OFS_STAT, 16'h0007);
        tick(2);
        chk(status_irq, 1'b0);
        rdc(OFS_STAT, 16'h0007);
        pulse(6, 1);
        tick(1);
        chk(status_irq, 1'b1);
        rdc(OFS_INTID, INTID_STATUS);
        rdc(OFS_STAT, 16'h0008);
        rdc(OFS_INTID, 16'h0000);
        wr(OFS_CTRL, 16'h0002);
        pulse(8, 1);
        tick(2);
        chk(status_irq, 1'b0);
        rdc(OFS_INTID, 16'h0000);
        rdc(OFS_STAT, 16'h000e);
        $display("status interrupt done");
    endtask

    task automatic t_tally();
        logic [15:0] v;
        wr(OFS_CTRL, 16'h000a);
        rd(OFS_STAT, v);
        pulse(3, 12);
        tick(2);
        rdc(OFS_INTID, INTID_STATUS);
        rdc(OFS_STAT, 16'h004e);
        pulse(3, 4);
        tick(2);
        rdc(OFS_INTID, 16'h0000);
        rdc(OFS_FAULT, 16'hff00);
        pulse(1, 12);
        rdc(OFS_FAULT, 16'hff60);
        pulse(1, 20);
        tick(2);
        chk(bus_off, 1'b1);
        chk(init_active, 1'b1);
        chk(can_tx, 1'b1);
        rdc(OFS_FAULT, 16'hffff);
        rdc(OFS_INTID, INTID_STATUS);
        $display("tallies done");
    endtask

    task automatic t_recover();
        int n;
        @(posedge clk);
        hold_dom <= 1'b1;
        wr(OFS_CTRL, 16'h000e);
        tick(300);
        chk(bus_off, 1'b1);
        chk(sample_bit, 1'b0);
        @(posedge clk);
        hold_dom <= 1'b0;
        n = 0;
        while (bus_off !== 1'b0 && n < 1000) begin
            tick(1);
            n++;
        end
        chk(bus_off, 1'b0);
        rdc(OFS_FAULT, 16'h0000);
        rdc(OFS_STAT, 16'h000d);
        $display("recovery done");
    endtask

    task automatic t_timing();
        measure(16);
        wr(OFS_CTRL, 16'h0041);
        wr(OFS_BTR, 16'h1202);
        wr(OFS_PRESCALER_UPPER_BITS, 16'h0001);
        rdc(OFS_PRESCALER_UPPER_BITS, 16'h0001);
        rdc(OFS_BTR, 16'h1202);
        wr(OFS_CTRL, 16'h0000);
        measure(402);
        $display("bit timing done");
    endtask

    initial begin
        #300000;
        err_total++;
        $display("watchdog expired");
        results();
    end

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_protect();
        t_codes();
        t_status();
        t_tally();
        t_recover();
        t_timing();
        results();
    end
endmodule

// ===== dv/cesbt_node.sv
module cesbt_node (
    input wire logic clk,
    input wire logic can_tx,
    input wire logic hold_dom,
    output logic can_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic line_r = 1'b1;
    // wired-and bus with one cycle of line delay
    always_ff @(posedge clk) begin
        line_r <= can_tx & ~hold_dom;
    end
    assign can_rx = line_r;
endmodule

// ===== rtl/cesbt_core.sv
// Added by the designer: the plain strobed port.
module cesbt_core #(
    parameter int RECOVERY_SEQS = cesbt_pkg::RECOVERY_SEQS,
    parameter int IDLE_RUN_BITS = cesbt_pkg::IDLE_RUN_BITS
) (
    input wire logic clk,
    input wire logic srst,
    input wire cesbt_pkg::cesbt_req_t req,
    output logic [15:0] rdata,
    input wire cesbt_pkg::cesbt_evt_t evt,
    input wire logic can_rx,
    output logic can_tx,
    output logic sample_pulse,
    output logic sample_bit,
    output logic status_irq,
    output logic bus_off,
    output logic init_active
);
    import cesbt_pkg::*;

    if (RECOVERY_SEQS < 1 || RECOVERY_SEQS > 255 || IDLE_RUN_BITS < 2 || IDLE_RUN_BITS > 15) begin
        $error("recovery counts out of range");
    end

    logic rx_m_r, rx_s_r, rx_prev_r;
    logic [7:0] ctrl_r;
    logic [14:0] btr_r;
    logic [3:0] prescaler_upper_bits_r;
    logic rx_ok_r, tx_ok_r;
    logic [2:0] lec_r;
    logic [7:0] rec_r, tec_r;
    logic int_pend_r;
    logic bus_off_flag_q_r, warn_q_r;
    cesbt_state_t state_r;
    logic [3:0] run_r;
    logic [7:0] seq_r;
    logic [9:0] pcnt_r;
    logic [5:0] q_r;
    logic [2:0] ext_r;
    logic [15:0] rdata_r;
    logic can_tx_r, sample_pulse_r, sample_bit_r, irq_r;

    logic init, cce;
    logic wr_ctrl, wr_stat, wr_btr, wr_prescaler_upper_bits, rd_stat;
    logic [9:0] presc;
    logic [5:0] phase_before_sample_eff, phase_after_sample_eff, sjw_eff, sample_idx, end_idx;
    logic tq, sample_now, rx_edge;
    logic idle_seq, bus_off_flag_enter, recovered;
    logic hw_upd;
    logic [2:0] hw_code;
    logic warn, rp, bus_off_flag, st_evt, err_evt, pend_set;
    logic [15:0] rd_val;

    assign init = ctrl_r[CTRL_INIT];
    assign cce = ctrl_r[CTRL_CCE];
    assign wr_ctrl = req.wr && req.addr == OFS_CTRL;
    assign wr_stat = req.wr && req.addr == OFS_STAT;
    assign wr_btr = req.wr && req.addr == OFS_BTR;
    assign wr_prescaler_upper_bits = req.wr && req.addr == OFS_PRESCALER_UPPER_BITS;
    assign rd_stat = req.rd && req.addr == OFS_STAT;

    // rx pin synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_m_r <= 1'b1;
            rx_s_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_m_r <= can_rx;
            rx_s_r <= rx_m_r;
            rx_prev_r <= rx_s_r;
        end
    end
    assign rx_edge = rx_prev_r && !rx_s_r;

    // control register, hardware sets init on bus-off
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_r <= CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= req.wdata[7:0] & CTRL_WMASK;
            end
            if (bus_off_flag_enter) begin
                ctrl_r[CTRL_INIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            btr_r <= BTR_RST;
            prescaler_upper_bits_r <= 4'h0;
        end else if (cce && init) begin
            if (wr_btr) begin
                btr_r <= req.wdata[14:0];
            end
            if (wr_prescaler_upper_bits) begin
                prescaler_upper_bits_r <= req.wdata[3:0];
            end
        end
    end

    assign presc = {prescaler_upper_bits_r, btr_r[5:0]};
    assign phase_before_sample_eff = {2'b00, btr_r[11:8]} + 6'd1;
    assign phase_after_sample_eff = {3'b000, btr_r[14:12]} + 6'd1;
    assign sjw_eff = {4'b0000, btr_r[7:6]} + 6'd1;
    // sync, segment one, sample, segment two
    assign sample_idx = phase_before_sample_eff + {3'b000, ext_r};
    assign end_idx = sample_idx + phase_after_sample_eff;
    assign tq = !init && pcnt_r == presc;
    assign sample_now = tq && q_r == sample_idx;

    always_ff @(posedge clk) begin
        if (srst || init || tq) begin
            pcnt_r <= 10'h000;
        end else begin
            pcnt_r <= pcnt_r + 10'h001;
        end
    end

    // quantum position with resync
    always_ff @(posedge clk) begin
        if (srst || init) begin
            q_r <= 6'h00;
            ext_r <= 3'h0;
        end else if (rx_edge && q_r != 6'h00 && q_r <= sample_idx) begin
            ext_r <= (q_r < sjw_eff) ? q_r[2:0] : sjw_eff[2:0];
        end else if (rx_edge && q_r > sample_idx) begin
            if (end_idx - q_r <= sjw_eff) begin
                q_r <= 6'h00;
                ext_r <= 3'h0;
            end else begin
                q_r <= q_r + sjw_eff;
            end
        end else if (tq) begin
            if (q_r == end_idx) begin
                q_r <= 6'h00;
                ext_r <= 3'h0;
            end else begin
                q_r <= q_r + 6'h01;
            end
        end
    end

    assign idle_seq = state_r == ST_RECOVER && !init && sample_now && rx_s_r
        && run_r == 4'(IDLE_RUN_BITS - 1);
    assign recovered = idle_seq && seq_r == 8'(RECOVERY_SEQS - 1);
    assign bus_off_flag_enter = state_r == ST_ACTIVE && evt.tec_inc8 && tec_r >= 8'd248;

    // bus-off state machine
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ST_ACTIVE;
        end else begin
            case (state_r)
                ST_ACTIVE: begin
                    if (bus_off_flag_enter) begin
                        state_r <= ST_BUS_OFF_FLAG_WAIT;
                    end
                end
                ST_BUS_OFF_FLAG_WAIT: begin
                    if (!init) begin
                        state_r <= ST_RECOVER;
                    end
                end
                ST_RECOVER: begin
                    if (recovered) begin
                        state_r <= ST_ACTIVE;
                    end
                end
                default: state_r <= ST_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst || state_r != ST_RECOVER) begin
            run_r <= 4'h0;
            seq_r <= 8'h00;
        end else if (idle_seq) begin
            run_r <= 4'h0;
            seq_r <= seq_r + 8'h01;
        end else if (sample_now) begin
            run_r <= rx_s_r ? run_r + 4'h1 : 4'h0;
        end
    end

    // fault tallies, cleared after recovery
    always_ff @(posedge clk) begin
        if (srst || recovered) begin
            rec_r <= 8'h00;
            tec_r <= 8'h00;
        end else begin
            if (evt.rec_inc8) begin
                rec_r <= (rec_r > 8'd247) ? 8'hff : rec_r + 8'd8;
            end else if (evt.rec_inc1) begin
                rec_r <= (rec_r == 8'hff) ? 8'hff : rec_r + 8'd1;
            end else if (evt.rec_dec && rec_r != 8'h00) begin
                rec_r <= rec_r - 8'd1;
            end
            if (state_r == ST_ACTIVE && evt.tec_inc8) begin
                tec_r <= (tec_r > 8'd247) ? 8'hff : tec_r + 8'd8;
            end else if (state_r == ST_ACTIVE && evt.tec_dec && tec_r != 8'h00) begin
                tec_r <= tec_r - 8'd1;
            end
        end
    end

    // fault code classification
    always_comb begin
        hw_upd = 1'b1;
        hw_code = CODE_NONE;
        if (evt.stuff_err) begin
            hw_code = CODE_STUFF;
        end else if (evt.form_err) begin
            hw_code = CODE_FORM;
        end else if (evt.ack_err) begin
            hw_code = CODE_ACK;
        end else if (evt.recessive_drive_fault) begin
            hw_code = CODE_REC_DRV;
        end else if (evt.dominant_drive_fault || idle_seq) begin
            hw_code = CODE_DOM_DRV;
        end else if (evt.crc_err) begin
            hw_code = CODE_CRC;
        end else if (evt.rx_done || evt.tx_done) begin
            hw_code = CODE_NONE;
        end else begin
            hw_upd = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lec_r <= CODE_NONE;
            rx_ok_r <= 1'b0;
            tx_ok_r <= 1'b0;
        end else begin
            if (hw_upd) begin
                lec_r <= hw_code;
            end else if (wr_stat) begin
                lec_r <= req.wdata[2:0];
            end
            if (evt.rx_done) begin
                rx_ok_r <= 1'b1;
            end else if (wr_stat) begin
                rx_ok_r <= req.wdata[4];
            end
            if (evt.tx_done) begin
                tx_ok_r <= 1'b1;
            end else if (wr_stat) begin
                tx_ok_r <= req.wdata[3];
            end
        end
    end

    assign bus_off_flag = state_r != ST_ACTIVE;
    assign warn = tec_r >= 8'(WARN_LIMIT) || rec_r >= 8'(WARN_LIMIT);
    assign rp = rec_r >= 8'(PASSIVE_LEVEL);
    assign st_evt = hw_upd || evt.rx_done || evt.tx_done;
    assign err_evt = bus_off_flag != bus_off_flag_q_r || warn != warn_q_r;
    assign pend_set = (st_evt && ctrl_r[CTRL_SIE]) || (err_evt && ctrl_r[CTRL_EIE]);

    always_ff @(posedge clk) begin
        if (srst) begin
            int_pend_r <= 1'b0;
            bus_off_flag_q_r <= 1'b0;
            warn_q_r <= 1'b0;
        end else begin
            bus_off_flag_q_r <= bus_off_flag;
            warn_q_r <= warn;
            if (pend_set) begin
                int_pend_r <= 1'b1;
            end else if (rd_stat) begin
                int_pend_r <= 1'b0;
            end
        end
    end

    // read mux
    always_comb begin
        case (req.addr)
            OFS_CTRL: rd_val = {8'h00, ctrl_r};
            OFS_STAT: rd_val = {8'h00, bus_off_flag, warn, tec_r >= 8'(PASSIVE_LEVEL) || rp,
                rx_ok_r, tx_ok_r, lec_r};
            OFS_FAULT: rd_val = {rp, (rec_r > 8'd127) ? 7'h7f : rec_r[6:0], tec_r};
            OFS_BTR: rd_val = {1'b0, btr_r};
            OFS_INTID: rd_val = int_pend_r ? INTID_STATUS : 16'h0000;
            OFS_PRESCALER_UPPER_BITS: rd_val = {12'h000, prescaler_upper_bits_r};
            default: rd_val = 16'h0000;
        endcase
    end

    // registered outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= 16'h0000;
            can_tx_r <= 1'b1;
            sample_pulse_r <= 1'b0;
            sample_bit_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            rdata_r <= req.rd ? rd_val : 16'h0000;
            can_tx_r <= (init || bus_off_flag) ? 1'b1 : evt.tx_bit;
            sample_pulse_r <= sample_now;
            if (sample_now) begin
                sample_bit_r <= rx_s_r;
            end
            irq_r <= int_pend_r && ctrl_r[CTRL_IE];
        end
    end

    assign rdata = rdata_r;
    assign can_tx = can_tx_r;
    assign sample_pulse = sample_pulse_r;
    assign sample_bit = sample_bit_r;
    assign status_irq = irq_r;
    assign bus_off = bus_off_flag_q_r;
    assign init_active = ctrl_r[CTRL_INIT];

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_stuff_code: assert property (evt.stuff_err |=> lec_r == CODE_STUFF)
        else $error("stuff error not coded 1");
    a_form_code: assert property (evt.form_err && !evt.stuff_err |=> lec_r == CODE_FORM)
        else $error("form error not coded 2");
    a_ack_code: assert property (evt.ack_err && !evt.stuff_err && !evt.form_err
        |=> lec_r == CODE_ACK)
        else $error("ack error not coded 3");
    a_recov_code: assert property (idle_seq && !evt.stuff_err && !evt.form_err
        && !evt.ack_err && !evt.recessive_drive_fault |=> lec_r == CODE_DOM_DRV)
        else $error("idle run not coded 5");
    a_crc_code: assert property (evt.crc_err && !evt.stuff_err && !evt.form_err
        && !evt.ack_err && !evt.recessive_drive_fault && !evt.dominant_drive_fault
        && !idle_seq |=> lec_r == CODE_CRC)
        else $error("crc error not coded 6");
    a_seven_hold: assert property (lec_r == CODE_UNUSED && !hw_upd && !wr_stat
        |=> lec_r == CODE_UNUSED)
        else $error("code 7 lost without bus event");
    a_clean_clear: assert property ((evt.rx_done || evt.tx_done) && !hw_code[0]
        && hw_code == CODE_NONE |=> lec_r == CODE_NONE)
        else $error("clean transfer did not clear code");
    a_err_irq: assert property (err_evt && ctrl_r[CTRL_EIE]
        |=> int_pend_r ##1 irq_r == ctrl_r[CTRL_IE] || $past(rd_stat))
        else $error("error interrupt missing");
    a_stat_irq: assert property (st_evt && ctrl_r[CTRL_SIE] |=> int_pend_r)
        else $error("status interrupt missing");
    a_sw_quiet: assert property (!pend_set && !int_pend_r |=> !int_pend_r)
        else $error("interrupt without enabled event");
    a_read_clear: assert property (rd_stat && !pend_set |=> !int_pend_r)
        else $error("status read did not clear");
    a_rp_bit: assert property (req.rd && req.addr == OFS_FAULT
        |=> rdata_r[15] == $past(rp) && rdata_r[7:0] == $past(tec_r))
        else $error("fault counter read wrong");
    a_btr_lock: assert property (!(cce && init) |=> $stable(btr_r))
        else $error("timing changed while locked");
    a_recover_done: assert property (recovered |=> rec_r == 8'h00 && tec_r == 8'h00
        && state_r == ST_ACTIVE)
        else $error("recovery did not clear tallies");

    c_stuff: cover property (evt.stuff_err ##1 lec_r == CODE_STUFF);
    c_idle_run: cover property (idle_seq);
    c_bus_off_flag_cycle: cover property (state_r == ST_RECOVER ##1 state_r == ST_ACTIVE);
    c_resync: cover property (rx_edge && ext_r == 3'h0 ##1 ext_r != 3'h0);
endmodule

// ===== rtl/cesbt_pkg.sv
// How it works
// - stuff error records fault code 1
// - form error records fault code 2
// - unacknowledged transmit records fault code 3
// - recessive sent, dominant seen: code 4
// - dominant sent, recessive seen: code 5
// - recovery writes code 5 per idle run
// - crc mismatch records fault code 6
// - software code 7 holds until bus event
// - bus-off/warning changes raise enabled error interrupt
// - success flags or code updates raise status interrupt
// - passive change or software writes raise nothing
// - status read clears pending 8000h identifier
// - receive tally shown in bits 14:8
// - bit 15 shows receive passive level
// - transmit tally shown in bits 7:0
// - post-sample segment bits 14:12, plus one
// - pre-sample segment bits 11:8, plus one
// - jump width bits 7:6, plus one
// - quantum is clock divided by prescaler+1
// - timing writable only with unlock and init
// - timing register resets to 2301h
// - clean transfer clears fault code to zero
// - four upper prescaler bits extend divider
// - recovery waits 129 idle runs, clears tallies
package cesbt_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_FAULT = 8'h08;
    localparam logic [7:0] OFS_BTR = 8'h0c;
    localparam logic [7:0] OFS_INTID = 8'h10;
    localparam logic [7:0] OFS_PRESCALER_UPPER_BITS = 8'h18;
    localparam int CTRL_INIT = 0;
    localparam int CTRL_IE = 1;
    localparam int CTRL_SIE = 2;
    localparam int CTRL_EIE = 3;
    localparam int CTRL_CCE = 6;
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic [7:0] CTRL_WMASK = 8'hef;
    localparam logic [14:0] BTR_RST = 15'h2301;
    localparam logic [15:0] INTID_STATUS = 16'h8000;
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_STUFF = 3'h1;
    localparam logic [2:0] CODE_FORM = 3'h2;
    localparam logic [2:0] CODE_ACK = 3'h3;
    localparam logic [2:0] CODE_REC_DRV = 3'h4;
    localparam logic [2:0] CODE_DOM_DRV = 3'h5;
    localparam logic [2:0] CODE_CRC = 3'h6;
    localparam logic [2:0] CODE_UNUSED = 3'h7;
    localparam int IDLE_RUN_BITS = 11;
    localparam int RECOVERY_SEQS = 129;
    localparam int WARN_LIMIT = 96;
    localparam int PASSIVE_LEVEL = 128;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } cesbt_req_t;

    typedef struct packed {
        logic stuff_err;
        logic form_err;
        logic ack_err;
        logic dominant_drive_fault;
        logic recessive_drive_fault;
        logic crc_err;
        logic rx_done;
        logic tx_done;
        logic tx_bit;
        logic rec_inc1;
        logic rec_inc8;
        logic rec_dec;
        logic tec_inc8;
        logic tec_dec;
    } cesbt_evt_t;

    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b001,
        ST_BUS_OFF_FLAG_WAIT = 3'b010,
        ST_RECOVER = 3'b100
    } cesbt_state_t;
endpackage
